/* File: ssc_lamp.v */
// indicator lamp blink generator
`timescale 1ns/100ps
`include "ssc_regs.vh"
module ssc_lamp #(
    parameter TICK_CYC = `SSC_TICK_CYC
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [1:0] state,
    output reg lamp
);
    reg [31:0] pre_q;
    reg [7:0] half_q;
    wire tick = (pre_q == TICK_CYC - 1);
    wire [7:0] limit = (state == `SSC_ST_RUN) ? `SSC_FAST_HALF_TICKS : `SSC_SLOW_HALF_TICKS;
    // prescaler and half period counter
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= 32'h0;
            half_q <= 8'h0;
            lamp <= 1'b1;
        end else if (ce) begin
            pre_q <= tick ? 32'h0 : pre_q + 32'h1;
            if (state == `SSC_ST_IDLE) begin
                half_q <= 8'h0;
                lamp <= 1'b1;
            end else if (tick) begin
                if (half_q >= limit - 8'h1) begin
                    half_q <= 8'h0;
                    lamp <= ~lamp;
                end else begin
                    half_q <= half_q + 8'h1;
                end
            end
        end
    end
endmodule

/* File: ssc_mem_model.sv */
// behavioural sequence memory seen by the controller
`timescale 1ns/100ps
`include "ssc_regs.vh"
module ssc_mem_model (
    input wire [`SSC_ADDR_W-1:0] addr,
    output wire [`SSC_U_W-1:0] voltage,
    output wire [`SSC_I_W-1:0] current,
    output wire [`SSC_T_W-1:0] dwell,
    output wire signal,
    output wire output_on
);
    // contents except dwell follow the address so a wrong location shows at once
    assign voltage = {8'h50, addr};
    assign current = {addr, 8'h0c};
    assign dwell = 16'h0002; // short dwell keeps runs brief
    assign signal = addr[0];
    assign output_on = addr[1];
endmodule

/* File: ssc_regs.vh */
// constants of the setpoint sequence controller
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_ADDR_W 8
`define SSC_U_W 16
`define SSC_I_W 16
`define SSC_T_W 16
`define SSC_REP_W 8
`define SSC_ST_IDLE 2'h0
`define SSC_ST_RUN 2'h1
`define SSC_ST_HOLD 2'h2
`define SSC_TICK_NS 10000000
`define SSC_CLK_NS 100
`define SSC_TICK_CYC (`SSC_TICK_NS / `SSC_CLK_NS)
`define SSC_SLOW_HALF_TICKS 8'h32
`define SSC_FAST_HALF_TICKS 8'h0a
`endif

/* File: ssc_seq.v */
// setpoint sequence controller top
`timescale 1ns/100ps
`include "ssc_regs.vh"
module ssc_seq #(
    parameter TICK_CYC = `SSC_TICK_CYC
) (
    input wire CLOCK,
    input wire RST,
    input wire CE,
    input wire RESTART_COMMAND,
    input wire STEP_COMMAND,
    input wire GOTO_START_COMMAND,
    input wire RESUME_COMMAND,
    input wire HOLD_COMMAND,
    input wire END_CURRENT_COMMAND,
    input wire [`SSC_ADDR_W-1:0] START_ADDR,
    input wire [`SSC_ADDR_W-1:0] STOP_ADDR,
    input wire [`SSC_REP_W-1:0] REPEAT_COUNT,
    input wire [`SSC_U_W-1:0] MEM_VOLTAGE,
    input wire [`SSC_I_W-1:0] MEM_CURRENT,
    input wire [`SSC_T_W-1:0] MEM_DWELL,
    input wire MEM_SIGNAL,
    input wire MEM_OUTPUT_ON,
    output wire [`SSC_ADDR_W-1:0] MEM_ADDR,
    output reg [`SSC_U_W-1:0] VOLTAGE_SETPOINT,
    output reg [`SSC_I_W-1:0] CURRENT_SETPOINT,
    output reg SIGNAL_OUTPUT,
    output reg POWER_OUTPUT_ON,
    output wire [1:0] SEQ_STATE,
    output wire STEP_MODE,
    output wire [`SSC_REP_W-1:0] REMAINING_REPEATS,
    output wire SEQUENCE_INDICATOR_LAMP
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // state codes
    localparam ST_IDLE = `SSC_ST_IDLE;
    localparam ST_RUN = `SSC_ST_RUN;
    localparam ST_HOLD = `SSC_ST_HOLD;

    // sequencer registers and their next values
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`SSC_ADDR_W-1:0] addr_q;
    reg [`SSC_ADDR_W-1:0] addr_d;
    reg [`SSC_REP_W-1:0] rrep_q;
    reg [`SSC_REP_W-1:0] rrep_d;
    reg step_mode_q;
    reg step_mode_d;
    // pending load of the memory word at addr_q
    reg apply_q;
    reg apply_d;
    reg apply_out_q; // load also takes output on/off from memory
    reg apply_out_d;
    reg timing_q; // dwell timer runs after the load
    reg timing_d;
    // dwell time left, in ticks
    reg [`SSC_T_W-1:0] dwell_q;
    reg [`SSC_T_W-1:0] dwell_d;
    // prescaler that makes one dwell tick
    reg [31:0] tick_q;
    reg [31:0] tick_d;
    // next values of the output registers
    reg [`SSC_U_W-1:0] voltage_d;
    reg [`SSC_I_W-1:0] current_d;
    reg signal_d;
    reg power_on_d;
    // decoded state
    reg in_idle;
    reg in_run;
    reg in_hold;

    // ------------------------------------------------------------
    // decoded conditions
    // ------------------------------------------------------------
    // prescaler wraps once per dwell tick
    wire tick = (tick_q == TICK_CYC - 1);
    // address after the current one, wrapping at stop to start
    wire at_stop = (addr_q == STOP_ADDR);
    wire [`SSC_ADDR_W-1:0] next_addr = at_stop ? START_ADDR : addr_q + 8'h01;
    // stop location of the final pass
    wire last_loc = at_stop && (rrep_q == 8'h00);
    // restart is also how a sequence leaves idle, there is no other start
    wire take_restart = RESTART_COMMAND;
    wire take_goto = !take_restart && GOTO_START_COMMAND && !in_idle;
    wire take_step = !take_restart && !take_goto && STEP_COMMAND && in_hold;
    wire prior3 = take_restart || take_goto || take_step;
    wire take_resume = !prior3 && RESUME_COMMAND && in_hold;
    wire take_hold = !prior3 && !take_resume && HOLD_COMMAND && in_run;
    wire take_end = !prior3 && !take_resume && !take_hold && END_CURRENT_COMMAND && in_hold;
    wire any_cmd = prior3 || take_resume || take_hold || take_end;
    // dwell countdown runs only when no command intervenes
    wire counting = !any_cmd && in_run && timing_q && !apply_q;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // status straight from the registers
    assign MEM_ADDR = addr_q;
    assign SEQ_STATE = state_q;
    assign STEP_MODE = step_mode_q;
    assign REMAINING_REPEATS = rrep_q;

    // ------------------------------------------------------------
    // state decode
    // ------------------------------------------------------------
    // one flag per sequencer state
    always @* begin
        in_idle = 1'b0;
        in_run = 1'b0;
        in_hold = 1'b0;
        case (state_q)
            ST_IDLE: begin
                in_idle = 1'b1;
            end
            ST_RUN: begin
                in_run = 1'b1;
            end
            ST_HOLD: begin
                in_hold = 1'b1;
            end
            default: begin
                in_idle = 1'b1; // unused code behaves as idle
            end
        endcase
    end

    // ------------------------------------------------------------
    // setpoint load
    // ------------------------------------------------------------
    // the word at the new address lands one cycle after it is selected
    always @* begin
        voltage_d = VOLTAGE_SETPOINT;
        current_d = CURRENT_SETPOINT;
        signal_d = SIGNAL_OUTPUT;
        if (apply_q) begin
            voltage_d = MEM_VOLTAGE;
            current_d = MEM_CURRENT;
            signal_d = MEM_SIGNAL;
        end
    end

    // ------------------------------------------------------------
    // command decode and sequencing
    // ------------------------------------------------------------
    // defaults keep every register except the load flags, which clear, then the taken command overrides
    always @* begin
        state_d = state_q;
        addr_d = addr_q;
        rrep_d = rrep_q;
        step_mode_d = step_mode_q;
        apply_d = 1'b0;
        apply_out_d = 1'b0;
        timing_d = timing_q;
        dwell_d = dwell_q;
        tick_d = tick_q;
        power_on_d = POWER_OUTPUT_ON;
        // a pending load may take the output state and arm the timer
        if (apply_q) begin
            if (apply_out_q) begin
                power_on_d = MEM_OUTPUT_ON;
            end
            if (timing_q) begin
                dwell_d = MEM_DWELL;
                tick_d = 32'h0;
            end
        end
        if (take_restart) begin
            // back to start, timed run, output forced on
            state_d = ST_RUN;
            power_on_d = 1'b1;
            addr_d = START_ADDR;
            rrep_d = REPEAT_COUNT;
            step_mode_d = 1'b0;
            apply_d = 1'b1;
            timing_d = 1'b1;
        end else if (take_goto) begin
            // start word, untimed, then hold
            state_d = ST_HOLD;
            power_on_d = 1'b1;
            addr_d = START_ADDR;
            rrep_d = REPEAT_COUNT;
            step_mode_d = 1'b1;
            apply_d = 1'b1;
            timing_d = 1'b0;
        end else if (take_step) begin
            // next word, untimed, repetitions untouched even on wrap
            addr_d = next_addr;
            step_mode_d = 1'b1;
            apply_d = 1'b1;
            timing_d = 1'b0;
        end else if (take_resume) begin
            // timed run from the next word, or idle when at the stop location of the final pass
            state_d = ST_RUN;
            step_mode_d = 1'b0;
            if (last_loc) begin
                state_d = ST_IDLE;
            end else begin
                if (at_stop) begin
                    rrep_d = rrep_q - 8'h01;
                end
                addr_d = next_addr;
                apply_d = 1'b1;
                timing_d = 1'b1;
            end
        end else if (take_hold) begin
            // suspended location keeps its setpoints
            state_d = ST_HOLD;
            timing_d = 1'b0;
        end else if (take_end) begin
            // end here: idle, output state from the current word
            state_d = ST_IDLE;
            step_mode_d = 1'b0;
            apply_d = 1'b1;
            apply_out_d = 1'b1;
            timing_d = 1'b0;
        end else if (counting) begin
            // dwell countdown in ticks
            tick_d = tick ? 32'h0 : tick_q + 32'h1;
            if (dwell_q == 16'h0000) begin
                if (last_loc) begin
                    state_d = ST_IDLE;
                    timing_d = 1'b0;
                end else begin
                    if (at_stop) begin
                        rrep_d = rrep_q - 8'h01;
                    end
                    addr_d = next_addr;
                    apply_d = 1'b1;
                end
            end else if (tick) begin
                dwell_d = dwell_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // everything freezes while the clock enable is low
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            addr_q <= 8'h00;
            rrep_q <= 8'h00;
            step_mode_q <= 1'b0;
            apply_q <= 1'b0;
            apply_out_q <= 1'b0;
            timing_q <= 1'b0;
            dwell_q <= 16'h0000;
            tick_q <= 32'h0;
            VOLTAGE_SETPOINT <= 16'h0000;
            CURRENT_SETPOINT <= 16'h0000;
            SIGNAL_OUTPUT <= 1'b0;
            POWER_OUTPUT_ON <= 1'b0;
        end else if (CE) begin
            state_q <= state_d;
            addr_q <= addr_d;
            rrep_q <= rrep_d;
            step_mode_q <= step_mode_d;
            apply_q <= apply_d;
            apply_out_q <= apply_out_d;
            timing_q <= timing_d;
            dwell_q <= dwell_d;
            tick_q <= tick_d;
            VOLTAGE_SETPOINT <= voltage_d;
            CURRENT_SETPOINT <= current_d;
            SIGNAL_OUTPUT <= signal_d;
            POWER_OUTPUT_ON <= power_on_d;
        end
    end

    // ------------------------------------------------------------
    // indicator lamp
    // ------------------------------------------------------------
    ssc_lamp #(.TICK_CYC(TICK_CYC)) u_lamp (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .state(state_q),
        .lamp(SEQUENCE_INDICATOR_LAMP)
    );
endmodule

/* File: ssc_seq_chk.sv */
// port assertions of the sequence controller
`timescale 1ns/100ps
`include "ssc_regs.vh"
module ssc_seq_chk (
    input wire CLOCK,
    input wire RST,
    input wire CE,
    input wire RESTART_COMMAND,
    input wire STEP_COMMAND,
    input wire GOTO_START_COMMAND,
    input wire RESUME_COMMAND,
    input wire END_CURRENT_COMMAND,
    input wire [`SSC_ADDR_W-1:0] START_ADDR,
    input wire [`SSC_ADDR_W-1:0] STOP_ADDR,
    input wire [`SSC_REP_W-1:0] REPEAT_COUNT,
    input wire [`SSC_U_W-1:0] MEM_VOLTAGE,
    input wire [`SSC_ADDR_W-1:0] MEM_ADDR,
    input wire [`SSC_U_W-1:0] VOLTAGE_SETPOINT,
    input wire POWER_OUTPUT_ON,
    input wire [1:0] SEQ_STATE,
    input wire STEP_MODE,
    input wire [`SSC_REP_W-1:0] REMAINING_REPEATS,
    input wire SEQUENCE_INDICATOR_LAMP
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // command qualifiers after priority
    wire live = CE && (SEQ_STATE != `SSC_ST_IDLE);
    wire hold = CE && (SEQ_STATE == `SSC_ST_HOLD) && !RESTART_COMMAND && !GOTO_START_COMMAND;
    wire last = (MEM_ADDR == STOP_ADDR) && (REMAINING_REPEATS == 0);
    sequence s_step_taken;
        hold && STEP_COMMAND;
    endsequence
    sequence s_goto_taken;
        live && GOTO_START_COMMAND && !RESTART_COMMAND;
    endsequence
    AST_RESTART_RUN: assert property (CE && RESTART_COMMAND |=>
        SEQ_STATE == `SSC_ST_RUN && POWER_OUTPUT_ON) else $error("restart did not run");
    AST_GOTO_HOLD: assert property (s_goto_taken |=> SEQ_STATE == `SSC_ST_HOLD &&
        POWER_OUTPUT_ON && STEP_MODE && MEM_ADDR == $past(START_ADDR)) else $error("goto wrong");
    AST_GOTO_REPS: assert property (s_goto_taken |=>
        REMAINING_REPEATS == $past(REPEAT_COUNT)) else $error("goto repeats not reloaded");
    AST_STEP_HOLD: assert property (s_step_taken |=> SEQ_STATE == `SSC_ST_HOLD && STEP_MODE &&
        $stable(POWER_OUTPUT_ON) && $stable(REMAINING_REPEATS)) else $error("step wrong");
    AST_STEP_SETPT: assert property (s_step_taken ##1 CE |=>
        VOLTAGE_SETPOINT == $past(MEM_VOLTAGE)) else $error("step setpoint not loaded");
    AST_RESUME_RUN: assert property (hold && !STEP_COMMAND && RESUME_COMMAND && !last |=>
        SEQ_STATE == `SSC_ST_RUN && $stable(POWER_OUTPUT_ON)) else $error("resume wrong");
    AST_END_IDLE: assert property (hold && !STEP_COMMAND && !RESUME_COMMAND &&
        END_CURRENT_COMMAND |=> SEQ_STATE == `SSC_ST_IDLE) else $error("end not idle");
    AST_IDLE_STAYS: assert property (SEQ_STATE == `SSC_ST_IDLE && !(CE && RESTART_COMMAND) |=>
        SEQ_STATE == `SSC_ST_IDLE) else $error("left idle");
    AST_IDLE_LAMP: assert property ((SEQ_STATE == `SSC_ST_IDLE) [*2] |->
        SEQUENCE_INDICATOR_LAMP) else $error("lamp blinks in idle");
endmodule
bind ssc_seq ssc_seq_chk u_chk (.CLOCK(CLOCK), .RST(RST), .CE(CE),
    .RESTART_COMMAND(RESTART_COMMAND), .STEP_COMMAND(STEP_COMMAND),
    .GOTO_START_COMMAND(GOTO_START_COMMAND), .RESUME_COMMAND(RESUME_COMMAND),
    .END_CURRENT_COMMAND(END_CURRENT_COMMAND), .START_ADDR(START_ADDR), .STOP_ADDR(STOP_ADDR),
    .REPEAT_COUNT(REPEAT_COUNT), .MEM_VOLTAGE(MEM_VOLTAGE), .MEM_ADDR(MEM_ADDR),
    .VOLTAGE_SETPOINT(VOLTAGE_SETPOINT), .POWER_OUTPUT_ON(POWER_OUTPUT_ON),
    .SEQ_STATE(SEQ_STATE), .STEP_MODE(STEP_MODE), .REMAINING_REPEATS(REMAINING_REPEATS),
    .SEQUENCE_INDICATOR_LAMP(SEQUENCE_INDICATOR_LAMP));

/* File: tb_ssc_seq.sv */
// self-checking bench of the sequence controller
`timescale 1ns/100ps
`include "ssc_regs.vh"
module tb_ssc_seq;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg ce = 1'b1;
    reg [5:0] cmd = 6'h00;
    wire [7:0] maddr;
    wire [7:0] rrep;
    wire [15:0] mv, mc, md, vset, cset;
    wire msig, mon, sig, pwr, smode, lamp;
    wire [1:0] st;
    integer fail_count = 0;
    integer n_checks = 0;
    integer i;
    integer per;
    always #50 clk = ~clk;
    ssc_mem_model MEM (.addr(maddr), .voltage(mv), .current(mc), .dwell(md), .signal(msig),
        .output_on(mon));
    ssc_seq #(.TICK_CYC(10)) DUT (.CLOCK(clk), .RST(rst), .CE(ce), .RESTART_COMMAND(cmd[0]),
        .STEP_COMMAND(cmd[1]), .GOTO_START_COMMAND(cmd[2]), .RESUME_COMMAND(cmd[3]),
        .HOLD_COMMAND(cmd[4]), .END_CURRENT_COMMAND(cmd[5]), .START_ADDR(8'h0b),
        .STOP_ADDR(8'h0e), .REPEAT_COUNT(8'h02), .MEM_VOLTAGE(mv), .MEM_CURRENT(mc),
        .MEM_DWELL(md), .MEM_SIGNAL(msig), .MEM_OUTPUT_ON(mon), .MEM_ADDR(maddr),
        .VOLTAGE_SETPOINT(vset), .CURRENT_SETPOINT(cset), .SIGNAL_OUTPUT(sig),
        .POWER_OUTPUT_ON(pwr), .SEQ_STATE(st), .STEP_MODE(smode), .REMAINING_REPEATS(rrep),
        .SEQUENCE_INDICATOR_LAMP(lamp));
    // compare and count
    task check(input [15:0] got, input [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // move just past the next rising edges
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one command pulse, then one more edge so setpoints have landed
    task pulse(input [5:0] c);
        cmd = c;
        tick(1);
        cmd = 6'h00;
        tick(1);
    endtask
    // cycles between two lamp changes, after the next change
    task measure(output integer cnt);
        integer k;
        reg old;
        cnt = 0;
        k = 0;
        old = lamp;
        while (lamp === old && k < 1200) begin
            tick(1);
            k = k + 1;
        end
        old = lamp;
        while (lamp === old && cnt < 1200) begin
            tick(1);
            cnt = cnt + 1;
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence
    initial begin
        tick(2);
        rst = 1'b0;
        tick(1);
        check({14'h0000, st}, {14'h0000, `SSC_ST_IDLE});
        check({smode, pwr, sig, lamp}, 16'h0001);
        check(vset | cset, 16'h0000);
        check({maddr, rrep}, 16'h0000);
        for (i = 1; i < 6; i = i + 1) begin
            cmd = 6'h01 << i;
            tick(1);
            cmd = 6'h00;
            tick(1);
            check({pwr, st}, {1'b0, `SSC_ST_IDLE});
        end
        cmd = 6'h3e;
        tick(1);
        cmd = 6'h00;
        repeat (120) begin
            tick(1);
            check(lamp, 1'b1);
        end
        rst = 1'b1;
        tick(1);
        check({lamp, st}, {1'b1, `SSC_ST_IDLE});
        rst = 1'b0;
        tick(2);
        check({lamp, pwr, st}, {2'b10, `SSC_ST_IDLE});
        // restart from idle starts a timed run
        cmd = 6'h01;
        tick(1);
        cmd = 6'h00;
        check({7'h00, pwr, maddr}, {8'h01, 8'h0b});
        check({6'h00, st, rrep}, {6'h00, `SSC_ST_RUN, 8'h02});
        tick(1);
        check(vset, 16'h500b);
        check(cset, 16'h0b0c);
        check({smode, sig}, 2'b01);
        tick(20);
        check(maddr, 8'h0b);
        tick(1);
        check(maddr, 8'h0c);
        measure(per);
        check(per[15:0], 16'd100);
        // restart from run, then hold at start
        pulse(6'h01);
        check({6'h00, st, vset[7:0]}, {6'h00, `SSC_ST_RUN, 8'h0b});
        pulse(6'h10);
        check({5'h00, pwr, st, maddr}, {5'h00, 1'b1, `SSC_ST_HOLD, 8'h0b});
        // steps keep output and repetitions
        pulse(6'h02);
        check(vset, 16'h500c);
        check({smode, pwr, st}, {2'b11, `SSC_ST_HOLD});
        pulse(6'h02);
        pulse(6'h02);
        check({maddr, rrep}, {8'h0e, 8'h02});
        pulse(6'h02);
        check({maddr, rrep}, {8'h0b, 8'h02});
        check(vset, 16'h500b);
        repeat (3) pulse(6'h02);
        // resume at stop wraps and uses one repetition
        pulse(6'h08);
        check({maddr, rrep}, {8'h0b, 8'h01});
        check({smode, pwr, st}, {2'b01, `SSC_ST_RUN});
        // go-to-start from run
        pulse(6'h04);
        check({maddr, rrep}, {8'h0b, 8'h02});
        check({smode, pwr, st}, {2'b11, `SSC_ST_HOLD});
        check(vset, 16'h500b);
        measure(per);
        check(per[15:0], 16'd500);
        // end at current address takes output state from memory
        pulse(6'h02);
        pulse(6'h20);
        check({pwr, st}, {1'b0, `SSC_ST_IDLE});
        check(vset, 16'h500c);
        check(lamp, 1'b1);
        // reset in the middle of a run
        pulse(6'h01);
        rst = 1'b1;
        tick(1);
        check({pwr, st}, {1'b0, `SSC_ST_IDLE});
        check(vset, 16'h0000);
        rst = 1'b0;
        tick(2);
        check({lamp, pwr, st}, {2'b10, `SSC_ST_IDLE});
        summarize;
    end
    // cut a hang short
    initial begin
        #(100 * 4000);
        fail_count = fail_count + 1;
        summarize;
    end
endmodule
